// file: common/supervisor_pkg.sv
// Constants, timing figures and state codes for the supply supervisor
package supervisor_pkg;

   // Fast clock rate and crystal-derived timebase rate
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned TIMEBASE_HZ = 32_768;

   // Fast-clock cycles per timebase tick, rounded down
   localparam int unsigned TIMEBASE_DIV_CYCLES = CLK_HZ / TIMEBASE_HZ;

   // Power-up and reset hold time, in ms
   localparam int unsigned POWERUP_HOLD_TIME_MS = 250;

   // Hold time in timebase ticks, rounded up
   localparam int unsigned POWERUP_HOLD_TICKS =
      (TIMEBASE_HZ * POWERUP_HOLD_TIME_MS + 999) / 1000;

   // Pushbutton debounce time, in ms
   localparam int unsigned DEBOUNCE_TIME_MS = 10;

   // Debounce time in timebase ticks, rounded up
   localparam int unsigned DEBOUNCE_TICKS =
      (TIMEBASE_HZ * DEBOUNCE_TIME_MS + 999) / 1000;

   // Watchdog period, in ms
   localparam int unsigned WATCHDOG_TIME_MS = 500;

   // Watchdog period in timebase ticks, rounded down
   localparam int unsigned WATCHDOG_TICKS = (TIMEBASE_HZ * WATCHDOG_TIME_MS) / 1000;

   // Level that the reset pin drive carries while enabled
   localparam logic RST_PIN_DRIVE_LEVEL = 1'b0;

   // Inactive level of the active-low SRAM enables
   localparam logic SRAM_ENABLE_OFF = 1'b1;

   // Supervisor states
   typedef enum logic [1:0] {
      ST_SUPPLY_LOW = 2'b00,
      ST_POWERUP = 2'b01,
      ST_RUN = 2'b10,
      ST_RESET_HOLD = 2'b11
   } sup_state_t;

endpackage : supervisor_pkg

// file: common/timebase_if.sv
// Timebase tick carried from the divider to the supervisor core
`timescale 1ns/1ps
interface timebase_if;
   logic tick;

   // Divider side drives the tick
   modport src (output tick);

   // Supervisor side consumes the tick
   modport sink (input tick);
endinterface : timebase_if

// file: dv/reset_wire_model.sv
// Host side of the open-drain reset wire with pullup and pushbutton
`timescale 1ns/1ps
module reset_wire_model (
   // Device drive
   input wire logic drive_i,
   input wire logic oe_i,
   // Pushbutton, low when pressed
   input wire logic button_n_i,
   // Resolved wire
   output logic wire_o
);
   // Any puller wins, else the pullup
   assign wire_o = ((oe_i && !drive_i) || !button_n_i) ? 1'b0 : 1'b1;
endmodule : reset_wire_model

// file: dv/supervisor_and_sram_enable_gating_tb.sv
// Self-checking bench for the supervisor and SRAM enable gating
`timescale 1ns/1ps
module supervisor_and_sram_enable_gating_tb;
   localparam int unsigned DIV = 4;
   localparam int unsigned HOLD = 5;
   localparam int unsigned DEB = 3;
   localparam int unsigned WD = 10;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic pg = 1'b0;
   logic kick_n = 1'b1;
   logic ram_n = 1'b1;
   logic up_n = 1'b1;
   logic lo_n = 1'b1;
   logic btn_n = 1'b1;
   logic wd_stop = 1'b0;
   logic pu_phase = 1'b1;
   logic pin_o, pin_oe, pin_w, hi_o, lo_o, ready, r, p, u, eh, el;
   int unsigned num_errors = 0;
   int unsigned total_checks = 0;
   int unsigned n;
   int unsigned cyc = 0;

   // 200 MHz clock
   initial begin
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   supply_supervisor #(.DIV_CYCLES(DIV), .HOLD_TICKS(HOLD), .DEBOUNCE_TICKS(DEB),
      .WATCHDOG_TICKS(WD)) u_dut (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .power_good_i(pg),
      .watchdog_kick_n_i(kick_n), .rst_pin_i(pin_w), .rst_pin_o(pin_o),
      .rst_pin_oe_o(pin_oe), .ram_enable_in_n_i(ram_n), .upper_lane_enable_n_i(up_n),
      .lower_lane_enable_n_i(lo_n), .sram_high_byte_enable_n_o(hi_o),
      .sram_low_byte_enable_n_o(lo_o), .access_ready_o(ready));

   reset_wire_model u_host (.drive_i(pin_o), .oe_i(pin_oe), .button_n_i(btn_n),
      .wire_o(pin_w));

   task automatic check(input logic [1:0] seen, input logic [1:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %b expected %b", $time, seen, exp);
      end
   endtask : check

   task automatic span(input int unsigned v, input int unsigned lo, input int unsigned hi);
      check({1'b0, v >= lo && v <= hi}, 2'b01);
   endtask : span

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic step(input int unsigned k);
      repeat (k) @(posedge ref_clk_i);
      #1;
   endtask : step

   // Cycles until ready reaches a level, bounded
   task automatic wait_ready(input logic lvl, output int unsigned cnt);
      cnt = 0;
      while (ready !== lvl && cnt < 2000) begin
         step(1);
         cnt++;
      end
   endtask : wait_ready

   // Random lanes and periodic kick, 1 ns after each edge
   always @(posedge ref_clk_i) begin
      #1;
      cyc++;
      {ram_n, up_n, lo_n} = 3'($urandom);
      kick_n = wd_stop || (cyc % 8 != 0);
   end

   // Reference model of the enable gating
   always @(posedge ref_clk_i) begin
      r = ready;
      p = pg;
      u = pu_phase;
      eh = ram_n | up_n;
      el = ram_n | lo_n;
      #2;
      if (nrst_i && (!p || (u && !r))) begin
         check({hi_o, lo_o}, 2'b11);
      end else if (nrst_i && r) begin
         check({hi_o, lo_o}, {eh, el});
      end
   end

   // Hang guard
   initial begin
      #60000;
      num_errors++;
      tally_and_finish();
   end

   initial begin
      n = $urandom(32'hbe77c935);
      step(6);
      nrst_i = 1'b1;
      step(20);
      check({pin_oe, ready}, 2'b10);
      pg = 1'b1;
      wait_ready(1'b1, n);
      span(n, HOLD * DIV, (HOLD + 2) * DIV + 2);
      pu_phase = 1'b0;
      check({pin_oe, pin_w}, 2'b01);
      step(200);
      $display("power-up and lanes done");
      wd_stop = 1'b1;
      wait_ready(1'b0, n);
      span(n, (WD - 2) * DIV, (WD + 2) * DIV + 2);
      wd_stop = 1'b0;
      check({pin_w, 1'b0}, 2'b00);
      wait_ready(1'b1, n);
      span(n, HOLD * DIV, (HOLD + 2) * DIV + 2);
      $display("watchdog done");
      btn_n = 1'b0;
      step(DIV);
      btn_n = 1'b1;
      step(30);
      check({pin_oe, ready}, 2'b01);
      btn_n = 1'b0;
      wait_ready(1'b0, n);
      span(n, DEB * DIV, (DEB + 2) * DIV + 2);
      btn_n = 1'b1;
      wait_ready(1'b1, n);
      span(n, HOLD * DIV, (HOLD + 2) * DIV + 2);
      $display("pushbutton done");
      pg = 1'b0;
      step(1);
      check({pin_oe, ready}, 2'b10);
      step(20);
      check({pin_oe, ready}, 2'b10);
      pu_phase = 1'b1;
      pg = 1'b1;
      wait_ready(1'b1, n);
      span(n, HOLD * DIV, (HOLD + 2) * DIV + 2);
      pu_phase = 1'b0;
      step(1);
      pu_phase = 1'b1;
      nrst_i = 1'b0;
      #1;
      check({pin_oe, ready}, 2'b10);
      step(2);
      nrst_i = 1'b1;
      wait_ready(1'b1, n);
      span(n, HOLD * DIV, (HOLD + 2) * DIV + 2);
      pu_phase = 1'b0;
      step(4);
      $display("supply loss and restart done");
      tally_and_finish();
   end
endmodule : supervisor_and_sram_enable_gating_tb

// file: dv/supervisor_properties.sv
// Concurrent checks on the supervisor top-level ports
`timescale 1ns/1ps
module supervisor_properties #(
   parameter int unsigned DIV_CYCLES = 4,
   parameter int unsigned WATCHDOG_TICKS = 10
) (
   // Clock, reset and inputs
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic power_good_i,
   input wire logic watchdog_kick_n_i,
   input wire logic ram_enable_in_n_i,
   input wire logic upper_lane_enable_n_i,
   input wire logic lower_lane_enable_n_i,
   // Outputs watched
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe_o,
   input wire logic sram_high_byte_enable_n_o,
   input wire logic sram_low_byte_enable_n_o,
   input wire logic access_ready_o
);
   // Cycles run without a kick
   int unsigned idle_ff;
   int unsigned nxt_idle;
   always_comb begin
      nxt_idle = (access_ready_o && watchdog_kick_n_i) ? idle_ff + 1 : 0;
   end
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         idle_ff <= 0;
      end else begin
         idle_ff <= nxt_idle;
      end
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   a_high_gate: assert property (
      !sram_high_byte_enable_n_o |-> $past(!ram_enable_in_n_i && !upper_lane_enable_n_i))
      else $error("high enable active without cause");
   a_ram_off: assert property (
      ram_enable_in_n_i |=> sram_high_byte_enable_n_o && sram_low_byte_enable_n_o)
      else $error("enable active with ram enable high");
   a_lane_follow: assert property (
      access_ready_o && power_good_i |=>
      sram_high_byte_enable_n_o == $past(ram_enable_in_n_i | upper_lane_enable_n_i) &&
      sram_low_byte_enable_n_o == $past(ram_enable_in_n_i | lower_lane_enable_n_i))
      else $error("lane enables wrong in run");
   a_supply_drop: assert property (
      !power_good_i |=> rst_pin_oe_o && !access_ready_o &&
      sram_high_byte_enable_n_o && sram_low_byte_enable_n_o)
      else $error("supply loss not handled");
   a_pin_low: assert property (rst_pin_o == 1'b0)
      else $error("reset pin drive level high");
   a_oe_ready: assert property (rst_pin_oe_o != access_ready_o)
      else $error("reset drive and ready disagree");
   a_hold_min: assert property ($fell(access_ready_o) |-> !access_ready_o [*8])
      else $error("reset pulse too short");
   a_wdog_bound: assert property (idle_ff <= (WATCHDOG_TICKS + 2) * DIV_CYCLES)
      else $error("watchdog did not expire");
endmodule : supervisor_properties

bind supply_supervisor supervisor_properties #(.DIV_CYCLES(DIV_CYCLES),
   .WATCHDOG_TICKS(WATCHDOG_TICKS)) u_props (.ref_clk_i, .nrst_i, .power_good_i,
   .watchdog_kick_n_i, .ram_enable_in_n_i, .upper_lane_enable_n_i, .lower_lane_enable_n_i,
   .rst_pin_o, .rst_pin_oe_o, .sram_high_byte_enable_n_o, .sram_low_byte_enable_n_o,
   .access_ready_o);

// file: src/supply_supervisor.sv
// Processor reset supervisor with watchdog, pushbutton and SRAM enable gating
//
// Summary of operation
// - High-byte SRAM enable goes low only with upper lane and ram enable low.
// - Low-byte SRAM enable goes low only with lower lane and ram enable low.
// - Reset asserted on bad supply, watchdog expiry, power-up interval, pushbutton.
// - External low on reset pin is debounced, then reset held at least 250 ms.
// - Reset pin is only pulled low or released, never driven high.
// - Host kicks watchdog low each period; a missed period asserts reset.
// - After supply becomes good, full access follows only after the 250 ms hold.
// - All inputs except supply and reset are ignored until the power-up hold has elapsed.
// - On supply return, reset stays active for 250 ms.
// - Bad supply or power-up hold forces both SRAM enables inactive high.
`timescale 1ns/1ps
module supply_supervisor #(
   parameter int unsigned DIV_CYCLES = supervisor_pkg::TIMEBASE_DIV_CYCLES,
   parameter int unsigned HOLD_TICKS = supervisor_pkg::POWERUP_HOLD_TICKS,
   parameter int unsigned DEBOUNCE_TICKS = supervisor_pkg::DEBOUNCE_TICKS,
   parameter int unsigned WATCHDOG_TICKS = supervisor_pkg::WATCHDOG_TICKS
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Supply monitor
   input wire logic power_good_i,
   // Host processor side
   input wire logic watchdog_kick_n_i,
   input wire logic rst_pin_i,
   output logic rst_pin_o,
   output logic rst_pin_oe_o,
   // SRAM enable inputs from host
   input wire logic ram_enable_in_n_i,
   input wire logic upper_lane_enable_n_i,
   input wire logic lower_lane_enable_n_i,
   // SRAM enable outputs
   output logic sram_high_byte_enable_n_o,
   output logic sram_low_byte_enable_n_o,
   // Status
   output logic access_ready_o
);

   // Counter widths, each able to hold its terminal value
   localparam int unsigned HOLD_W = $clog2(HOLD_TICKS + 1);
   localparam int unsigned DB_W = $clog2(DEBOUNCE_TICKS + 1);
   localparam int unsigned WD_W = $clog2(WATCHDOG_TICKS + 1);
   localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_TICKS);
   localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_TICKS);
   localparam logic [WD_W-1:0] WD_LAST = WD_W'(WATCHDOG_TICKS);

   // Timebase tick from the divider
   timebase_if tb_bus ();

   timebase_div #(
      .DIV_CYCLES(DIV_CYCLES)
   ) u_timebase (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .tb(tb_bus.src)
   );

   logic tick;
   assign tick = tb_bus.tick;

   supervisor_pkg::sup_state_t state_ff;
   supervisor_pkg::sup_state_t nxt_state;
   logic [HOLD_W-1:0] hold_cnt_ff;
   logic [HOLD_W-1:0] nxt_hold_cnt;
   logic [DB_W-1:0] db_cnt_ff;
   logic [DB_W-1:0] nxt_db_cnt;
   logic [WD_W-1:0] wd_cnt_ff;
   logic [WD_W-1:0] nxt_wd_cnt;
   logic rst_oe_ff;
   logic nxt_rst_oe;
   logic ce_hi_n_ff;
   logic nxt_ce_hi_n;
   logic ce_lo_n_ff;
   logic nxt_ce_lo_n;
   logic ready_ff;
   logic nxt_ready;

   // Event terms seen by the state machine
   logic hold_done;
   logic pb_fire;
   logic wd_fire;
   logic in_run;
   logic access_ok;

   // Terminal conditions of the tick counters
   always_comb begin
      hold_done = tick && (hold_cnt_ff == HOLD_LAST);
      pb_fire = tick && (db_cnt_ff == DB_LAST);
      wd_fire = tick && (wd_cnt_ff == WD_LAST);
      in_run = (state_ff == supervisor_pkg::ST_RUN);
      // SRAM reachable only with good supply after the power-up hold
      access_ok = power_good_i &&
         ((state_ff == supervisor_pkg::ST_RUN) ||
          (state_ff == supervisor_pkg::ST_RESET_HOLD));
   end

   // Next state of the supervisor
   always_comb begin
      nxt_state = state_ff;
      if (!power_good_i) begin
         nxt_state = supervisor_pkg::ST_SUPPLY_LOW;
      end else begin
         case (state_ff)
            supervisor_pkg::ST_SUPPLY_LOW: begin
               nxt_state = supervisor_pkg::ST_POWERUP;
            end
            supervisor_pkg::ST_POWERUP: begin
               // Nothing but supply and the hold counter is looked at here
               if (hold_done) begin
                  nxt_state = supervisor_pkg::ST_RUN;
               end
            end
            supervisor_pkg::ST_RUN: begin
               if (pb_fire || wd_fire) begin
                  nxt_state = supervisor_pkg::ST_RESET_HOLD;
               end
            end
            supervisor_pkg::ST_RESET_HOLD: begin
               if (hold_done) begin
                  nxt_state = supervisor_pkg::ST_RUN;
               end
            end
            default: begin
               nxt_state = supervisor_pkg::ST_SUPPLY_LOW;
            end
         endcase
      end
   end

   // Hold counter runs in every state up to its terminal value, cleared on each state change
   always_comb begin
      nxt_hold_cnt = hold_cnt_ff;
      if (nxt_state != state_ff) begin
         nxt_hold_cnt = '0;
      end else if (tick && (hold_cnt_ff != HOLD_LAST)) begin
         nxt_hold_cnt = hold_cnt_ff + HOLD_W'(1);
      end
   end

   // Pushbutton debounce counts ticks of a steady external low
   // Own pull is excluded so the device never re-triggers on its own reset
   always_comb begin
      nxt_db_cnt = '0;
      if (in_run && !rst_oe_ff && !rst_pin_i && (nxt_state == state_ff)) begin
         nxt_db_cnt = db_cnt_ff;
         if (tick && (db_cnt_ff != DB_LAST)) begin
            nxt_db_cnt = db_cnt_ff + DB_W'(1);
         end
      end
   end

   // Watchdog counts ticks since the last kick while running
   always_comb begin
      nxt_wd_cnt = '0;
      if (in_run && watchdog_kick_n_i && (nxt_state == state_ff)) begin
         nxt_wd_cnt = wd_cnt_ff;
         if (tick && (wd_cnt_ff != WD_LAST)) begin
            nxt_wd_cnt = wd_cnt_ff + WD_W'(1);
         end
      end
   end

   // Output next values: reset pull, gated SRAM enables, ready flag
   always_comb begin
      nxt_rst_oe = (nxt_state != supervisor_pkg::ST_RUN);
      nxt_ce_hi_n = supervisor_pkg::SRAM_ENABLE_OFF;
      nxt_ce_lo_n = supervisor_pkg::SRAM_ENABLE_OFF;
      if (access_ok && !ram_enable_in_n_i) begin
         nxt_ce_hi_n = upper_lane_enable_n_i;
         nxt_ce_lo_n = lower_lane_enable_n_i;
      end
      nxt_ready = (nxt_state == supervisor_pkg::ST_RUN);
   end

   // State and counter registers
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= supervisor_pkg::ST_SUPPLY_LOW;
         hold_cnt_ff <= '0;
         db_cnt_ff <= '0;
         wd_cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         hold_cnt_ff <= nxt_hold_cnt;
         db_cnt_ff <= nxt_db_cnt;
         wd_cnt_ff <= nxt_wd_cnt;
      end
   end

   // Output registers; reset pulls the pin and shuts the SRAM off
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_oe_ff <= 1'b1;
         ce_hi_n_ff <= supervisor_pkg::SRAM_ENABLE_OFF;
         ce_lo_n_ff <= supervisor_pkg::SRAM_ENABLE_OFF;
         ready_ff <= 1'b0;
      end else begin
         rst_oe_ff <= nxt_rst_oe;
         ce_hi_n_ff <= nxt_ce_hi_n;
         ce_lo_n_ff <= nxt_ce_lo_n;
         ready_ff <= nxt_ready;
      end
   end

   // Open-drain reset: drive level is always low, only the enable moves
   assign rst_pin_o = supervisor_pkg::RST_PIN_DRIVE_LEVEL;
   assign rst_pin_oe_o = rst_oe_ff;

   // SRAM enables and status
   assign sram_high_byte_enable_n_o = ce_hi_n_ff;
   assign sram_low_byte_enable_n_o = ce_lo_n_ff;
   assign access_ready_o = ready_ff;

endmodule : supply_supervisor

// file: src/timebase_div.sv
// Divider making a one-cycle tick at the crystal timebase rate
`timescale 1ns/1ps
module timebase_div #(
   parameter int unsigned DIV_CYCLES = supervisor_pkg::TIMEBASE_DIV_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Tick out
   timebase_if.src tb
);

   localparam int unsigned DIV_W = (DIV_CYCLES > 1) ? $clog2(DIV_CYCLES) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CYCLES - 1);

   logic [DIV_W-1:0] div_cnt_ff;
   logic [DIV_W-1:0] nxt_div_cnt;
   logic tick_ff;
   logic nxt_tick;

   // Wrap the counter and flag the wrap cycle
   always_comb begin
      nxt_tick = (div_cnt_ff == DIV_LAST);
      if (div_cnt_ff == DIV_LAST) begin
         nxt_div_cnt = '0;
      end else begin
         nxt_div_cnt = div_cnt_ff + DIV_W'(1);
      end
   end

   // Divider registers
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tb.tick = tick_ff;

endmodule : timebase_div
